// [shared/dcs_defines.vh]
// Offsets, field positions, reset values and widths of the DMA status block
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH
`define DCS_NCHAN 8
`define DCS_CHW 3
`define DCS_ADRW 8
`define DCS_OFS_COLL 8'h00
`define DCS_OFS_ACT 8'h04
`define DCS_XWC_LSB 0
`define DCS_XWC_MSB 7
`define DCS_PWC_LSB 8
`define DCS_PWC_MSB 15
`define DCS_PPS_LSB 0
`define DCS_PPS_MSB 7
`define DCS_LAC_LSB 8
`define DCS_LAC_MSB 11
`define DCS_LAC_RST 4'hF
`define DCS_FLAG_RST 8'h00
`endif

// [rtl/dcs_flag_bank.v]
// Bank of sticky event flags with software clear
`timescale 1ns/10ps
`include "dcs_defines.vh"
module dcs_flag_bank #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk,
  input wire rstN,
  // Events and clear
  input wire [W-1:0] setPulse,
  input wire [W-1:0] clrMask,
  // Flags
  output reg [W-1:0] flags_q
);
  wire [W-1:0] flags_d;

  // Set beats clear so a collision in the clearing cycle is kept
  assign flags_d = (flags_q & ~clrMask) | setPulse;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      flags_q <= {W{1'b0}};
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule // dcs_flag_bank

// [rtl/dcs_chan_tracker.v]
// Last active channel and ping-pong buffer indicators
`timescale 1ns/10ps
`include "dcs_defines.vh"
module dcs_chan_tracker (
  // Clock and reset
  input wire clk,
  input wire rstN,
  // Transfer completion from channel engines
  input wire xferDone,
  input wire [`DCS_CHW-1:0] xferChan,
  input wire [`DCS_NCHAN-1:0] pingpongSelB,
  // Status
  output reg [3:0] lastActiveChannel_q,
  output reg [`DCS_NCHAN-1:0] pingpongBufferIndicator_q
);
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lastActiveChannel_q <= `DCS_LAC_RST;
      pingpongBufferIndicator_q <= `DCS_FLAG_RST;
    end else begin
      // Top bit forced low: a transfer never loads a reserved code; only reset loads 4'hF
      if (xferDone) begin
        lastActiveChannel_q <= {1'b0, xferChan};
      end
      pingpongBufferIndicator_q <= pingpongSelB;
    end
  end
endmodule // dcs_chan_tracker

// [rtl/dcs_status_top.v]
// Top of the DMA collision and channel status block with Wishbone slave
// Contract
// - Eight DMA-RAM write-collision flags sit in bits 7..0 of the collision register, bit n for channel n.
// - A collision flag reads 1 once a collision was detected on its channel and 0 otherwise.
// - Bits 11..8 of the activity register give the binary number 0..7 of the last transferring channel.
// - Hardware updates that field on every completed transfer and software can only read it.
// - Eight peripheral write-collision flags sit in bits 15..8 of the collision register, bit 8 for channel 0.
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "dcs_defines.vh"
module dcs_status_top (
  // Clock and reset
  input wire core_clk,
  input wire nrst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`DCS_ADRW-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg wb_ack_o,
  output reg [31:0] wb_dat_o,
  // Collision events, one-cycle pulses per channel
  input wire [`DCS_NCHAN-1:0] dmaRamWriteCollision,
  input wire [`DCS_NCHAN-1:0] peripheralWriteCollision,
  // Transfer completion
  input wire xferDone,
  input wire [`DCS_CHW-1:0] xferChan,
  input wire [`DCS_NCHAN-1:0] pingpongSelB
);
  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rstSync1_q;
  reg rstSync2_q;
  wire rstN;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  assign rstN = rstSync2_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire busReq;
  wire selColl;
  wire selAct;
  wire wrCommit;
  wire [15:0] laneMask;
  wire [15:0] clrMask;
  localparam [`DCS_ADRW-1:0] OFS_COLL = `DCS_OFS_COLL;
  localparam [`DCS_ADRW-1:0] OFS_ACT = `DCS_OFS_ACT;

  assign busReq = wb_cyc_i & wb_stb_i;
  // Word decode; low address bits ignored
  assign selColl = (wb_adr_i[`DCS_ADRW-1:2] == OFS_COLL[`DCS_ADRW-1:2]);
  assign selAct = (wb_adr_i[`DCS_ADRW-1:2] == OFS_ACT[`DCS_ADRW-1:2]);
  // Write lands on the edge where the master sees ack
  assign wrCommit = busReq & wb_we_i & wb_ack_o;
  assign laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Writing 0 clears a flag, writing 1 leaves it alone
  assign clrMask = (wrCommit & selColl) ? (laneMask & ~wb_dat_i[15:0]) : 16'h0000;

  // ----------------------------------------------------------------
  // Status state
  // ----------------------------------------------------------------
  wire [`DCS_NCHAN-1:0] dmaRamWriteCollisionFlag;
  wire [`DCS_NCHAN-1:0] peripheralWriteCollisionFlag;
  wire [3:0] lastActiveChannel;
  wire [`DCS_NCHAN-1:0] pingpongBufferIndicator;

  dcs_flag_bank #(.W(`DCS_NCHAN)) uXwc (
    .clk(core_clk),
    .rstN(rstN),
    .setPulse(dmaRamWriteCollision),
    .clrMask(clrMask[`DCS_XWC_MSB:`DCS_XWC_LSB]),
    .flags_q(dmaRamWriteCollisionFlag)
  );

  dcs_flag_bank #(.W(`DCS_NCHAN)) uPwc (
    .clk(core_clk),
    .rstN(rstN),
    .setPulse(peripheralWriteCollision),
    .clrMask(clrMask[`DCS_PWC_MSB:`DCS_PWC_LSB]),
    .flags_q(peripheralWriteCollisionFlag)
  );

  dcs_chan_tracker uTrk (
    .clk(core_clk),
    .rstN(rstN),
    .xferDone(xferDone),
    .xferChan(xferChan),
    .pingpongSelB(pingpongSelB),
    .lastActiveChannel_q(lastActiveChannel),
    .pingpongBufferIndicator_q(pingpongBufferIndicator)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  reg [31:0] rdData;

  always @* begin
    rdData = 32'h0000_0000;
    if (selColl) begin
      rdData[`DCS_XWC_MSB:`DCS_XWC_LSB] = dmaRamWriteCollisionFlag;
      rdData[`DCS_PWC_MSB:`DCS_PWC_LSB] = peripheralWriteCollisionFlag;
    end else if (selAct) begin
      rdData[`DCS_LAC_MSB:`DCS_LAC_LSB] = lastActiveChannel;
      rdData[`DCS_PPS_MSB:`DCS_PPS_LSB] = pingpongBufferIndicator;
    end
  end

  // ----------------------------------------------------------------
  // Ack and read data
  // ----------------------------------------------------------------
  // Activity register has no write path at all
  always @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
      if (busReq & ~wb_ack_o & ~wb_we_i) begin
        wb_dat_o <= rdData;
      end else if (!busReq) begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end
endmodule // dcs_status_top

// [sim/dcs_partner.sv]
// Far-side model: processor and peripheral collisions, channel transfers
`timescale 1ns/10ps
module dcs_partner (
  input wire core_clk,
  output logic [7:0] dCol = 8'h00,
  output logic [7:0] pCol = 8'h00,
  output logic [7:0] ppSel = 8'h00,
  output logic xDone = 1'b0,
  output logic [2:0] xCh = 3'h0
);
  task automatic collide(input logic [7:0] d, input logic [7:0] p);
    @(posedge core_clk) {dCol, pCol} <= {d, p};
    @(posedge core_clk) {dCol, pCol} <= 16'h0000;
  endtask
  // Channel is not valid outside the pulse, so show its inverse
  task automatic xfer(input logic [2:0] c, input logic [7:0] pp);
    @(posedge core_clk) {xDone, xCh, ppSel} <= {1'b1, c, pp};
    @(posedge core_clk) {xDone, xCh} <= {1'b0, ~c};
  endtask
endmodule // dcs_partner

// [sim/dcs_status_top_sva.sv]
// Port checker of the DMA status block
`timescale 1ns/10ps
module dcs_status_top_sva (
  input wire core_clk, input wire nrst,
  input wire wb_cyc_i, input wire wb_stb_i, input wire wb_we_i,
  input wire [7:0] wb_adr_i, input wire wb_ack_o, input wire [31:0] wb_dat_o,
  input wire [7:0] dmaRamWriteCollision, input wire [7:0] peripheralWriteCollision,
  input wire xferDone, input wire [2:0] xferChan
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Collisions seen since the last write to the collision word must read set
  logic [7:0] dSeen;
  logic [7:0] pSeen;
  logic [3:0] lacModel;
  wire wrColl = wb_ack_o && wb_we_i && (wb_adr_i[7:2] == 6'h00);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dSeen <= 8'h00;
      pSeen <= 8'h00;
      lacModel <= 4'hF;
    end else begin
      dSeen <= wrColl ? dmaRamWriteCollision : (dSeen | dmaRamWriteCollision);
      pSeen <= wrColl ? peripheralWriteCollision : (pSeen | peripheralWriteCollision);
      if (xferDone) begin
        lacModel <= {1'b0, xferChan};
      end
    end
  end
  sequence sRd(a);
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == a;
  endsequence
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle after request");
  AST_XWC: assert property (sRd(0) |->
    (wb_dat_o[7:0] & $past(dSeen)) == $past(dSeen))
    else $error("dma ram collision flag not set");
  AST_PWC: assert property (sRd(0) |->
    (wb_dat_o[15:8] & $past(pSeen)) == $past(pSeen))
    else $error("peripheral collision flag not set");
  AST_LAC: assert property (sRd(1) |-> wb_dat_o[11:8] == $past(lacModel))
    else $error("last channel wrong");
  AST_RSV: assert property (sRd(1) |-> !wb_dat_o[11] || wb_dat_o[11:8] == 4'hF)
    else $error("reserved channel code");
  // Read data clears on the edge after the request drops
  AST_IDLE: assert property (!wb_cyc_i ##1 !wb_cyc_i |-> wb_dat_o == 32'h0)
    else $error("data not idle");
endmodule // dcs_status_top_sva
bind dcs_status_top dcs_status_top_sva u_sva (.core_clk(core_clk), .nrst(nrst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .dmaRamWriteCollision(dmaRamWriteCollision),
  .peripheralWriteCollision(peripheralWriteCollision), .xferDone(xferDone),
  .xferChan(xferChan));

// [sim/tb_dcs_status_top.sv]
// Self-checking bench of the DMA status block
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb_dcs_status_top;
  logic core_clk = 0, nrst = 0, cyc = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd;
  wire ack, xDone;
  wire [31:0] dat;
  wire [7:0] dCol, pCol, ppSel;
  wire [2:0] xCh;
  int miscompares = 0, num_checks = 0;
  always #25 core_clk = ~core_clk;
  dcs_status_top u_dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(dat), .dmaRamWriteCollision(dCol), .peripheralWriteCollision(pCol),
    .xferDone(xDone), .xferChan(xCh), .pingpongSelB(ppSel));
  dcs_partner u_far (.core_clk(core_clk), .dCol(dCol), .pCol(pCol), .ppSel(ppSel),
    .xDone(xDone), .xCh(xCh));
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk) {cyc, we, adr, sel, wdat} <= {1'b1, w, a, s, 16'h0, d};
    do begin @(posedge core_clk); n++; end while (ack !== 1'b1 && n < 20);
    rd = dat;
    cyc <= 1'b0;
    `CHK(ack, 1'b1)
  endtask
  task t_reset;
    bus(0, 8'h00, 4'hF, 16'h0); `CHK(rd, 32'h0)
    bus(0, 8'h04, 4'hF, 16'h0); `CHK(rd, 32'h0F00)
  endtask
  task t_flags;
    for (int n = 0; n < 8; n++) begin
      u_far.collide(8'h01 << n, 8'h80 >> n);
      bus(0, 8'h00, 4'hF, 16'h0); `CHK(rd, {16'h0, 8'h80 >> n, 8'h01 << n})
      bus(1, 8'h00, 4'hF, 16'h0);
      bus(0, 8'h00, 4'hF, 16'h0); `CHK(rd, 32'h0)
    end
    u_far.collide(8'hFF, 8'hFF);
    // Only the enabled low lane may clear
    bus(1, 8'h00, 4'h1, 16'h0);
    bus(0, 8'h00, 4'hF, 16'h0); `CHK(rd, 32'hFF00)
  endtask
  task t_lac;
    for (int c = 0; c < 8; c++) begin
      u_far.xfer(c[2:0], 8'h5A ^ c[7:0]);
      bus(0, 8'h04, 4'hF, 16'h0); `CHK(rd, {20'h0, 1'b0, c[2:0], 8'h5A ^ c[7:0]})
    end
    bus(1, 8'h04, 4'hF, 16'h0);
    bus(0, 8'h04, 4'hF, 16'h0); `CHK(rd, 32'h075D)
    bus(0, 8'h08, 4'hF, 16'h0); `CHK(rd, 32'h0)
  endtask
  task t_rerst;
    u_far.collide(8'hFF, 8'hFF);
    u_far.xfer(3'h2, 8'h3C);
    @(posedge core_clk) nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(0, 8'h00, 4'hF, 16'h0); `CHK(rd, 32'h0)
    bus(0, 8'h04, 4'hF, 16'h0); `CHK(rd, 32'h0F3C)
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_flags;
    t_lac;
    t_rerst;
    give_verdict;
  end
endmodule // tb_dcs_status_top
